// >>> design/serial_baud_break.sv
// baud generator and sync break receive control, top module
// assumes one-cycle register strobes and pins from outside the clock domain
//
// Contract
// - baud rate is divisor output halved
// - on internal oscillator, count clock is divided oscillator
// - trigger clears with completion interrupt
// - trigger reads zero, clears by itself
// - failed break reception holds flag at one
`timescale 1ns/1ps
module serial_baud_break (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    input  wire logic       cpu_on_osc,
    input  wire logic       osc_pin,
    input  wire logic       rxd,
    output logic            baud_clk,
    output logic            baud_tick,
    output logic            done_irq,
    output logic            break_flag,
    output logic            result_valid,
    input  wire logic       result_ready,
    output logic [7:0]      result_data
);
    typedef struct packed {
        logic                    power;
        logic                    txe;
        logic                    rxe;
        logic [3:0]              clksel;
        logic [7:0]              divisor;
        logic                    trig;
        logic                    flag;
        serial_baud_pkg::brk_state_t fsm;
        logic [9:0]              presc;
        logic [1:0]              osc_cnt;
        logic                    osc_s1;
        logic                    osc_s2;
        logic                    osc_s3;
        logic                    rxd_s1;
        logic                    rxd_s2;
        logic [7:0]              dcnt;
        logic                    half;
        logic                    tick;
        logic                    irq;
        logic [7:0]              low_cnt;
        logic [7:0]              rdata;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;
    result_if    res ();

    logic osc_tick;
    logic base_tick;
    logic cnt_pulse;
    logic arm;

    // true when the low sel bits of the prescaler are all ones
    function automatic logic presc_tap(input logic [9:0] p, input logic [3:0] sel);
        logic [9:0] mask;
        mask = 10'h3FF >> (4'hA - sel);
        return (p & mask) == mask;
    endfunction

    // ------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------
    // one tick per four rising oscillator edges, seen after the synchroniser
    assign osc_tick = s.osc_s2 && !s.osc_s3 && (s.osc_cnt == serial_baud_pkg::OSC_DIV_LAST);

    always_comb
    begin
        if (cpu_on_osc || s.clksel == serial_baud_pkg::CLKSEL_OSC)
            base_tick = osc_tick;
        else if (s.clksel > 4'hA)
            base_tick = 1'b0;
        else
            base_tick = presc_tap(s.presc, s.clksel);
    end

    assign cnt_pulse = s.power && base_tick && (s.dcnt <= 8'h01);

    // arming only with power and rx enabled
    assign arm = wr && addr == serial_baud_pkg::OFS_EXTCTL && wdata[serial_baud_pkg::TRIG_BIT]
                 && s.power && s.rxe && s.fsm == serial_baud_pkg::BRK_IDLE;

    // result towards the buffer
    assign res.valid = s.fsm == serial_baud_pkg::BRK_DONE;
    assign res.data  = s.low_cnt;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s        = s;
        next_s.osc_s1 = osc_pin;
        next_s.osc_s2 = s.osc_s1;
        next_s.osc_s3 = s.osc_s2;
        next_s.rxd_s1 = rxd;
        next_s.rxd_s2 = s.rxd_s1;
        next_s.presc  = s.presc + 10'h001;
        next_s.tick   = 1'b0;
        next_s.irq    = 1'b0;
        next_s.rdata  = 8'h00;
        if (s.osc_s2 && !s.osc_s3)
            next_s.osc_cnt = s.osc_cnt + 2'h1;

        // register writes; left to software
        if (wr)
        begin
            unique case (addr)
                serial_baud_pkg::OFS_MODE:
                begin
                    next_s.power = wdata[serial_baud_pkg::POWER_BIT];
                    next_s.txe   = wdata[serial_baud_pkg::TXE_BIT];
                    next_s.rxe   = wdata[serial_baud_pkg::RXE_BIT];
                end
                serial_baud_pkg::OFS_CLKSEL:  next_s.clksel  = wdata[3:0];
                serial_baud_pkg::OFS_DIVISOR: next_s.divisor = wdata;
                default: ;
            endcase
        end

        if (!s.power)
        begin
            next_s.dcnt = s.divisor;
            next_s.half = 1'b0;
        end
        else if (cnt_pulse)
        begin
            next_s.dcnt = s.divisor;
            next_s.half = !s.half;
            next_s.tick = s.half;
        end
        else if (base_tick)
            next_s.dcnt = s.dcnt - 8'h01;

        if (rd)
        begin
            unique case (addr)
                serial_baud_pkg::OFS_MODE:
                    next_s.rdata = {s.power, s.txe, s.rxe, 5'h00};
                serial_baud_pkg::OFS_CLKSEL:  next_s.rdata = {4'h0, s.clksel};
                serial_baud_pkg::OFS_DIVISOR: next_s.rdata = s.divisor;
                serial_baud_pkg::OFS_STATUS:
                    next_s.rdata = {6'h00, s.fsm != serial_baud_pkg::BRK_IDLE, s.flag};
                default: next_s.rdata = 8'h00;
            endcase
        end

        // break reception sequence
        unique case (s.fsm)
            serial_baud_pkg::BRK_IDLE:
            begin
                if (arm)
                begin
                    next_s.trig = 1'b1;
                    next_s.flag = 1'b0;
                    next_s.fsm  = serial_baud_pkg::BRK_WAIT;
                end
            end
            serial_baud_pkg::BRK_WAIT:
            begin
                next_s.low_cnt = 8'h00;
                if (!s.rxd_s2)
                    next_s.fsm = serial_baud_pkg::BRK_LOW;
            end
            serial_baud_pkg::BRK_LOW:
            begin
                if (s.rxd_s2)
                begin
                    if (s.low_cnt >= serial_baud_pkg::SBF_MIN_BITS)
                        next_s.fsm = serial_baud_pkg::BRK_DONE;
                    else
                    begin
                        next_s.flag = 1'b1;
                        next_s.trig = 1'b0;
                        next_s.fsm  = serial_baud_pkg::BRK_IDLE;
                    end
                end
                else if (s.tick && s.low_cnt != 8'hFF)
                    next_s.low_cnt = s.low_cnt + 8'h01;
            end
            serial_baud_pkg::BRK_DONE:
            begin
                if (res.ready)
                begin
                    next_s.trig = 1'b0;
                    next_s.irq  = 1'b1;
                    next_s.fsm  = serial_baud_pkg::BRK_IDLE;
                end
            end
        endcase

        // power off abandons a reception in progress
        if (!s.power && s.fsm != serial_baud_pkg::BRK_IDLE)
        begin
            next_s.trig = 1'b0;
            next_s.fsm  = serial_baud_pkg::BRK_IDLE;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s         <= '0;
            s.clksel  <= serial_baud_pkg::CLKSEL_RESET;
            s.divisor <= serial_baud_pkg::DIVISOR_RESET;
            s.dcnt    <= serial_baud_pkg::DIVISOR_RESET;
            s.rxd_s1  <= 1'b1;
            s.rxd_s2  <= 1'b1;
            s.fsm     <= serial_baud_pkg::BRK_IDLE;
        end
        else
            s <= next_s;
    end

    // result buffer
    result_buffer u_buf (
        .mclk      (mclk),
        .rstn      (rstn),
        .fill      (res.buf_side),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result_data)
    );

    // outputs straight from flops
    assign rdata      = s.rdata;
    assign baud_clk   = s.half;
    assign baud_tick  = s.tick;
    assign done_irq   = s.irq;
    assign break_flag = s.flag;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_trig_zero;
        rd && addr == serial_baud_pkg::OFS_EXTCTL |=> rdata == 8'h00;
    endproperty
    a_trig_zero: assert property (p_trig_zero) else $error("trigger read nonzero");

    property p_halve;
        s.power && cnt_pulse |=> baud_clk != $past(baud_clk) ##1 1'b1;
    endproperty
    a_halve: assert property (p_halve) else $error("baud clock missed toggle");

    property p_halve_stable;
        s.power && !cnt_pulse |=> $stable(baud_clk);
    endproperty
    a_halve_stable: assert property (p_halve_stable) else $error("baud clock moved");

    property p_irq_clear;
        done_irq |-> !s.trig && $past(s.trig) && $past(s.fsm) == serial_baud_pkg::BRK_DONE;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("trigger not cleared");

    property p_flag_held;
        break_flag && !arm |=> break_flag;
    endproperty
    a_flag_held: assert property (p_flag_held) else $error("flag lost");

    property p_fail_flag;
        s.fsm == serial_baud_pkg::BRK_LOW && s.rxd_s2 && s.power
            && s.low_cnt < serial_baud_pkg::SBF_MIN_BITS |=> break_flag && !s.trig;
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("failure not flagged");

    property p_reload;
        cnt_pulse && !(wr && addr == serial_baud_pkg::OFS_DIVISOR) |=> s.dcnt == s.divisor;
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded");

    property p_osc_gate;
        cpu_on_osc && !osc_tick |-> !base_tick;
    endproperty
    a_osc_gate: assert property (p_osc_gate) else $error("count off oscillator");
endmodule

// >>> design/serial_baud_pkg.sv
// constants for the serial baud generator and break receiver
// assumes one 50 MHz clock and a plain 8-bit register port
package serial_baud_pkg;
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam logic [2:0] OFS_MODE    = 3'h0; // serial_mode_register
    localparam logic [2:0] OFS_CLKSEL  = 3'h1; // base clock select
    localparam logic [2:0] OFS_DIVISOR = 3'h2; // baud_divisor_control
    localparam logic [2:0] OFS_EXTCTL  = 3'h3; // serial_extended_control
    localparam logic [2:0] OFS_STATUS  = 3'h4; // flag and busy

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned POWER_BIT = 7; // unit_power_enable
    localparam int unsigned TXE_BIT   = 6; // transmit_enable_bit
    localparam int unsigned RXE_BIT   = 5; // receive_enable_bit
    localparam int unsigned TRIG_BIT  = 6; // break_receive_trigger
    localparam int unsigned FLAG_BIT  = 0; // break_reception_flag
    localparam int unsigned BUSY_BIT  = 1;
    localparam logic [3:0] CLKSEL_RESET = 4'h0;
    localparam logic [3:0] CLKSEL_OSC   = 4'hF; // internal oscillator as base
    localparam logic [7:0] DIVISOR_RESET = 8'hFF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned PRESC_W = 10;        // taps mclk/1 .. mclk/1024
    localparam logic [1:0] OSC_DIV_LAST = 2'h3;  // oscillator divided by 4
    localparam logic [7:0] SBF_MIN_BITS = 8'h0B; // shortest sync break, bits

    typedef enum logic [1:0] {
        BRK_IDLE = 2'b00,
        BRK_WAIT = 2'b01,
        BRK_LOW  = 2'b10,
        BRK_DONE = 2'b11
    } brk_state_t;
endpackage

// >>> design/result_if.sv
// carrier between break receiver and its result buffer
// assumes both ends on mclk
`timescale 1ns/1ps
interface result_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport buf_side (input valid, input data, output ready);
endinterface

// >>> design/result_buffer.sv
// two-entry shift buffer for break length results
// assumes consumer may stall with out_ready low for any time
`timescale 1ns/1ps
module result_buffer (
    input  wire logic   mclk,
    input  wire logic   rstn,
    result_if.buf_side  fill,
    output logic        out_valid,
    input  wire logic   out_ready,
    output logic [7:0]  out_data
);
    typedef struct packed {
        logic [7:0] e0;
        logic [7:0] e1;
        logic       v0;
        logic       v1;
    } buf_state_t;

    buf_state_t s;
    buf_state_t next_s;

    // ------------------------------------------------------------
    // shift logic
    // ------------------------------------------------------------
    // pop from head, then place the new word in the first free slot
    always_comb
    begin
        next_s = s;
        if (s.v0 && out_ready)
        begin
            next_s.e0 = s.e1;
            next_s.v0 = s.v1;
            next_s.v1 = 1'b0;
        end
        if (fill.valid && !s.v1)
        begin
            if (!next_s.v0)
            begin
                next_s.e0 = fill.data;
                next_s.v0 = 1'b1;
            end
            else
            begin
                next_s.e1 = fill.data;
                next_s.v1 = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    // out_valid and out_data come from the head entry flops, fill.ready from the second entry
    assign fill.ready = !s.v1;
    assign out_valid  = s.v0;
    assign out_data   = s.e0;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_hold_stall;
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold_stall: assert property (p_hold_stall) else $error("result dropped under stall");
endmodule

// >>> dv/remote_sender.sv
// far-side transmitter model: drives a low period on the receive line
// assumes baud_tick from the block under test paces the low period
`timescale 1ns/1ps
module remote_sender (
    input  wire logic       mclk,
    input  wire logic       baud_tick,
    input  wire logic       start,
    input  wire logic [7:0] low_len,
    output logic            rxd,
    output logic            busy
);
    logic [7:0] left;

    initial
    begin
        rxd = 1'b1;
        busy = 1'b0;
        left = 8'h00;
    end

    // hold the line low for low_len baud periods, idle high otherwise
    always @(posedge mclk)
    begin
        if (start)
        begin
            busy <= 1'b1;
            rxd <= 1'b0;
            left <= low_len;
        end
        else if (busy && baud_tick)
        begin
            if (left <= 8'h01)
            begin
                rxd <= 1'b1;
                busy <= 1'b0;
            end
            left <= left - 8'h01;
        end
    end
endmodule

// >>> dv/serial_baud_break_test.sv
// self-checking bench for the baud generator and break receiver
// assumes the design files and the far-side model are compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module serial_baud_break_test;
    logic       mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, start = 1'b0;
    logic       cpu_on_osc = 1'b0, osc_pin = 1'b0, result_ready = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, low_len = 8'h00, rv, rdata, result_data;
    logic       rxd, baud_clk, baud_tick, done_irq, break_flag, result_valid, busy;
    int         n_errors = 0, checks_done = 0, cyc = 0, n_irq = 0, n_pop = 0, t0, g, k;

    serial_baud_break i_serial_baud_break (.mclk(mclk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_on_osc(cpu_on_osc),
        .osc_pin(osc_pin), .rxd(rxd), .baud_clk(baud_clk), .baud_tick(baud_tick),
        .done_irq(done_irq), .break_flag(break_flag), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data));
    remote_sender i_remote_sender (.mclk(mclk), .baud_tick(baud_tick), .start(start),
        .low_len(low_len), .rxd(rxd), .busy(busy));

    // --------------------------------------------------------------
    // clocks, cycle count and timeout
    // --------------------------------------------------------------
    initial
    begin
        forever #10 mclk = ~mclk;
    end
    initial
    begin
        #5;
        forever #20 osc_pin = ~osc_pin;
    end
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (done_irq === 1'b1) n_irq <= n_irq + 1;
        if (result_valid === 1'b1 && result_ready) n_pop <= n_pop + 1;
        if (cyc == 60000)
        begin
            n_errors++;
            results();
        end
    end

    // --------------------------------------------------------------
    // register port and helpers
    // --------------------------------------------------------------
    task results;
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task next_tick;
        int j;
        j = 0;
        do begin @(posedge mclk); j++; end while (baud_tick !== 1'b1 && j < 4000);
    endtask
    // power off, set base and divisor, power on, measure tick spacing
    task baud_run(input logic [3:0] sel, input logic [7:0] dv, input int exp_gap);
        wreg(serial_baud_pkg::OFS_MODE, 8'h00);
        wreg(serial_baud_pkg::OFS_CLKSEL, {4'h0, sel});
        wreg(serial_baud_pkg::OFS_DIVISOR, dv);
        rreg(serial_baud_pkg::OFS_DIVISOR, rv);
        `CHK("divisor", dv, rv)
        wreg(serial_baud_pkg::OFS_MODE, 8'h80);
        next_tick();
        t0 = cyc;
        next_tick();
        g = cyc - t0;
        `CHK("tick gap", exp_gap, g)
        `CHK("baud level at tick", 1'b0, baud_clk)
    endtask
    task brk(input logic [7:0] len);
        int j;
        for (j = 0; j < 4000 && busy; j++) @(posedge mclk);
        wreg(serial_baud_pkg::OFS_EXTCTL, 8'h40);
        @(posedge mclk);
        start <= 1'b1;
        low_len <= len;
        @(posedge mclk);
        start <= 1'b0;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        rreg(serial_baud_pkg::OFS_DIVISOR, rv);
        `CHK("divisor reset", serial_baud_pkg::DIVISOR_RESET, rv)
        wreg(3'h6, 8'h5A);
        rreg(3'h6, rv);
        `CHK("unmapped", 8'h00, rv)
        baud_run(4'h0, 8'h04, 8);
        baud_run(4'h1, 8'h03, 12);
        baud_run(4'h0, 8'h00, 2);
        baud_run(4'h2, 8'hFF, 2040);
        // oscillator divided by four overrides selection
        cpu_on_osc <= 1'b1;
        baud_run(4'h0, 8'h02, 32);
        cpu_on_osc <= 1'b0;
        wreg(serial_baud_pkg::OFS_MODE, 8'h00);
        wreg(serial_baud_pkg::OFS_CLKSEL, 8'h0B);
        wreg(serial_baud_pkg::OFS_MODE, 8'h80);
        for (k = 0; k < 64 && baud_clk !== 1'b1; k++) @(posedge mclk);
        `CHK("stopped select", 64, k)
        baud_run(4'h0, 8'h02, 4);
        brk(8'h0E);
        for (k = 0; k < 4000 && busy; k++) @(posedge mclk);
        rreg(serial_baud_pkg::OFS_STATUS, rv);
        `CHK("status idle", 8'h00, rv)
        `CHK("no irq", 0, n_irq)
        wreg(serial_baud_pkg::OFS_MODE, 8'hA0);
        for (int b = 1; b <= 2; b++)
        begin
            brk(8'h0E);
            for (k = 0; k < 4000 && n_irq < b; k++) @(posedge mclk);
            `CHK("irq count", b, n_irq)
            rreg(serial_baud_pkg::OFS_EXTCTL, rv);
            `CHK("trigger reads", 8'h00, rv)
            rreg(serial_baud_pkg::OFS_STATUS, rv);
            `CHK("busy cleared", 8'h00, rv)
        end
        `CHK("held valid", 1'b1, result_valid)
        `CHK("length", 1'b1, result_data >= serial_baud_pkg::SBF_MIN_BITS)
        @(posedge mclk);
        result_ready <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK("drained", 1'b0, result_valid)
        `CHK("pops", 2, n_pop)
        // short low period fails and holds the flag
        brk(8'h05);
        for (k = 0; k < 4000 && break_flag !== 1'b1; k++) @(posedge mclk);
        repeat (50) @(posedge mclk);
        `CHK("flag held", 1'b1, break_flag)
        rreg(serial_baud_pkg::OFS_STATUS, rv);
        `CHK("status flag", 8'h01, rv)
        `CHK("no irq on fail", 2, n_irq)
        // rearm clears flag and receives again
        brk(8'h0E);
        `CHK("flag cleared", 1'b0, break_flag)
        for (k = 0; k < 4000 && n_irq < 3; k++) @(posedge mclk);
        `CHK("rearm irq", 3, n_irq)
        results();
    end
endmodule
